// >>> logic/dotsm_pkg.sv
// Package for disparity output formatting and frame time tagging
package dotsm_pkg;

  // =====================================================
  // Disparity coding
  localparam int DISP_WIDTH = 12;
  localparam int FRAC_BITS = 4;
  localparam int INT_BITS = DISP_WIDTH - FRAC_BITS;
  localparam logic [11:0] DISP_INVALID = 12'hfff;

  // =====================================================
  // Time base
  localparam int CLK_FREQ_MHZ = 100;
  localparam int US_NS = 1000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CYC_PER_US = US_NS / CLK_PERIOD_NS;
  localparam int TS_WIDTH = 64;
  localparam int SEQ_WIDTH = 32;
  localparam logic [63:0] TS_RESET = 64'h0;
  localparam logic [31:0] SEQ_RESET = 32'h0;

  // =====================================================
  // Modes
  typedef enum logic [1:0] {
    DOTSM_SYNC_NONE = 2'b00,
    DOTSM_SYNC_PIN = 2'b01,
    DOTSM_SYNC_SERVER = 2'b10
  } dotsm_sync_type;

  typedef enum logic [0:0] {
    DOTSM_SRC_TRIGGER = 1'b0,
    DOTSM_SRC_RECEIVE = 1'b1
  } dotsm_tsrc_type;

  typedef enum logic [1:0] {
    DOTSM_ST_IDLE = 2'b00,
    DOTSM_ST_PEND = 2'b01,
    DOTSM_ST_SEND = 2'b10
  } dotsm_state_type;

  // Frame tag carried with each result pair
  typedef struct packed {
    logic [63:0] stamp;
    logic [31:0] seq;
  } dotsm_tag_type;

  // One disparity sample from the matcher
  typedef struct packed {
    logic [11:0] disp;
    logic invalid;
  } dotsm_pix_type;

endpackage : dotsm_pkg

// >>> logic/dotsm_usclock.sv
// Microsecond time base with load and clear
`timescale 1ns/1ps
module dotsm_usclock
  import dotsm_pkg::*;
#(
  parameter int DIV = CYC_PER_US
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic clear_i,
  input wire logic load_i,
  input wire logic [63:0] load_val_i,
  output logic [63:0] us_o
);

  logic [7:0] div_reg;
  logic [7:0] div_next;
  logic [63:0] us_reg;
  logic [63:0] us_next;

  // =====================================================
  // Divider and counter
  always_comb begin
    div_next = div_reg + 8'h01;
    us_next = us_reg;
    if (div_reg == 8'(DIV - 1)) begin
      div_next = 8'h00;
      us_next = us_reg + 64'h1;
    end
    // Clear restarts the fraction too, so edges align exactly
    if (clear_i) begin
      div_next = 8'h00;
      us_next = TS_RESET;
    end else if (load_i) begin
      div_next = 8'h00;
      us_next = load_val_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      div_reg <= 8'h00;
      us_reg <= TS_RESET;
    end else begin
      div_reg <= div_next;
      us_reg <= us_next;
    end
  end

  assign us_o = us_reg;

endmodule : dotsm_usclock

// >>> logic/dotsm_pixfmt.sv
// Disparity pixel formatter: invalid code and raw preview value
`timescale 1ns/1ps
module dotsm_pixfmt
  import dotsm_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic valid_i,
  input wire dotsm_pix_type pix_i,
  output logic valid_o,
  output logic [11:0] disp_o,
  output logic [7:0] raw_o
);

  logic valid_reg;
  logic valid_next;
  logic [11:0] disp_reg;
  logic [11:0] disp_next;
  logic [7:0] raw_reg;
  logic [7:0] raw_next;

  // =====================================================
  // Formatting
  always_comb begin
    valid_next = valid_i;
    disp_next = pix_i.disp;
    if (pix_i.invalid) begin
      disp_next = DISP_INVALID;
    end
    raw_next = disp_next[DISP_WIDTH-1:FRAC_BITS];
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      valid_reg <= 1'b0;
      disp_reg <= 12'h000;
      raw_reg <= 8'h00;
    end else begin
      valid_reg <= valid_next;
      disp_reg <= disp_next;
      raw_reg <= raw_next;
    end
  end

  assign valid_o = valid_reg;
  assign disp_o = disp_reg;
  assign raw_o = raw_reg;

endmodule : dotsm_pixfmt

// >>> logic/dotsm_top.sv
// Disparity output stage: pixel coding, frame tags, host gating
// =====================================================
`timescale 1ns/1ps
module dotsm_top
  import dotsm_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic SRST_I,
  input wire dotsm_sync_type SYNC_MODE_I,
  input wire dotsm_tsrc_type TS_SRC_I,
  input wire logic SYNC_PIN_I,
  input wire logic SERVER_LOAD_I,
  input wire logic [63:0] SERVER_TIME_I,
  input wire logic TRIGGER_I,
  input wire logic FRAME_RX_I,
  input wire logic NET_SOURCE_I,
  input wire dotsm_tag_type NET_TAG_I,
  input wire logic PAIR_DONE_I,
  input wire logic CAMERAS_OK_I,
  input wire logic PREVIEW_OPEN_I,
  input wire logic [3:0] PREVIEW_ID_I,
  input wire logic PREVIEW_CLOSE_I,
  input wire logic PIX_VALID_I,
  input wire dotsm_pix_type PIX_I,
  output logic PIX_VALID_O,
  output logic [11:0] DISP_O,
  output logic [7:0] RAW_O,
  output logic TAG_VALID_O,
  output dotsm_tag_type TAG_O,
  output logic PROC_RUN_O,
  output logic HOST_XFER_EN_O,
  output logic PREVIEW_EN_O,
  output logic [3:0] PREVIEW_OWNER_O
);

  // =====================================================
  // Declarations
  // Pin synchroniser state
  logic sync_meta_reg;
  logic sync_meta_next;
  logic sync_s_reg;
  logic sync_s_next;
  logic sync_d_reg;
  logic sync_d_next;
  logic sync_rise;

  // Microsecond clock hookup
  logic [63:0] now_us;
  logic srv_load;

  // Capture state machine
  dotsm_state_type state_reg;
  dotsm_state_type state_next;
  logic [63:0] stamp_reg;
  logic [63:0] stamp_next;
  logic [63:0] stamp_neg;
  logic capture_evt;
  logic local_start;
  logic net_start;
  logic pix_gate;
  logic pair_fire;

  // Tag and sequence state
  logic [31:0] seq_reg;
  logic [31:0] seq_next;
  logic tag_valid_reg;
  logic tag_valid_next;
  dotsm_tag_type tag_reg;
  dotsm_tag_type tag_next;

  // Run and preview state
  logic proc_run_reg;
  logic proc_run_next;
  logic prev_en_reg;
  logic prev_en_next;
  logic [3:0] owner_reg;
  logic [3:0] owner_next;
  logic host_en_reg;
  logic host_en_next;
  logic owner_close;
  logic free_open;

  // =====================================================
  // Pin synchroniser and edge detect
  // First stage may go metastable, so only the second and third stages feed logic
  always_comb begin
    sync_meta_next = SYNC_PIN_I;
    sync_s_next = sync_meta_reg;
    sync_d_next = sync_s_reg;
  end

  // Synchroniser registers
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      sync_meta_reg <= 1'b0;
      sync_s_reg <= 1'b0;
      sync_d_reg <= 1'b0;
    end else begin
      sync_meta_reg <= sync_meta_next;
      sync_s_reg <= sync_s_next;
      sync_d_reg <= sync_d_next;
    end
  end

  // rising sync edge
  // Low after reset matches an idle pin, so no false edge follows reset
  assign sync_rise = (SYNC_MODE_I == DOTSM_SYNC_PIN) && sync_s_reg && !sync_d_reg;

  // =====================================================
  // Microsecond clock
  // server time load
  assign srv_load = (SYNC_MODE_I == DOTSM_SYNC_SERVER) && SERVER_LOAD_I;

  dotsm_usclock #(
    .DIV(CYC_PER_US)
  ) u_clock (
    .clk_i(CORE_CLK_I),
    .srst_i(SRST_I),
    .clear_i(sync_rise),
    .load_i(srv_load),
    .load_val_i(SERVER_TIME_I),
    .us_o(now_us)
  );

  // =====================================================
  // Pixel formatting
  // Pixels only pass while a pair is being sent
  assign pix_gate = PIX_VALID_I && (state_reg == DOTSM_ST_SEND);

  dotsm_pixfmt u_pix (
    .clk_i(CORE_CLK_I),
    .srst_i(SRST_I),
    .valid_i(pix_gate),
    .pix_i(PIX_I),
    .valid_o(PIX_VALID_O),
    .disp_o(DISP_O),
    .raw_o(RAW_O)
  );

  // =====================================================
  // Frame capture
  // stamp source select
  assign capture_evt = (TS_SRC_I == DOTSM_SRC_TRIGGER) ? TRIGGER_I : FRAME_RX_I;

  // Start decode, refused until processing runs
  assign local_start = proc_run_reg && !NET_SOURCE_I && capture_evt;
  assign net_start = proc_run_reg && NET_SOURCE_I && FRAME_RX_I;

  // negative interval since capture
  // Two's complement; a later edge still sums up since the clock restarted at zero
  assign stamp_neg = 64'h0 - (now_us - stamp_reg);

  // Pair finished while sending
  assign pair_fire = (state_reg == DOTSM_ST_SEND) && PAIR_DONE_I;

  // Capture state and stamp next values
  always_comb begin
    state_next = state_reg;
    stamp_next = stamp_reg;
    unique case (state_reg)
      DOTSM_ST_IDLE: begin
        if (local_start) begin
          stamp_next = now_us;
          state_next = DOTSM_ST_PEND;
        end else if (net_start) begin
          state_next = DOTSM_ST_SEND;
        end
      end
      DOTSM_ST_PEND: begin
        if (sync_rise) begin
          stamp_next = stamp_neg;
        end
        // Reception stamping has already seen its frame
        if (FRAME_RX_I || TS_SRC_I == DOTSM_SRC_RECEIVE) begin
          state_next = DOTSM_ST_SEND;
        end
      end
      DOTSM_ST_SEND: begin
        if (sync_rise && !NET_SOURCE_I) begin
          stamp_next = stamp_neg;
        end
        if (PAIR_DONE_I) begin
          state_next = DOTSM_ST_IDLE;
        end
      end
      default: begin
        state_next = DOTSM_ST_IDLE;
      end
    endcase
  end

  // Capture registers
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      state_reg <= DOTSM_ST_IDLE;
      stamp_reg <= TS_RESET;
    end else begin
      state_reg <= state_next;
      stamp_reg <= stamp_next;
    end
  end

  // =====================================================
  // Tag and sequence number
  // Tag valid is a one-cycle pulse, the tag itself holds
  always_comb begin
    seq_next = seq_reg;
    tag_valid_next = 1'b0;
    tag_next = tag_reg;
    if (pair_fire) begin
      // tag every pair
      // Pulse dropped when nobody listens, the count still advances
      tag_valid_next = host_en_reg || prev_en_reg;
      if (NET_SOURCE_I) begin
        tag_next = NET_TAG_I;
      end else begin
        tag_next.stamp = stamp_reg;
        tag_next.seq = seq_reg;
        seq_next = seq_reg + 32'h1;
      end
    end
  end

  // Tag registers
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      seq_reg <= SEQ_RESET;
      tag_valid_reg <= 1'b0;
      tag_reg <= '0;
    end else begin
      seq_reg <= seq_next;
      tag_valid_reg <= tag_valid_next;
      tag_reg <= tag_next;
    end
  end

  // =====================================================
  // Processing run and preview ownership
  // Close only counts from the page that owns the stream
  assign owner_close = prev_en_reg && PREVIEW_CLOSE_I && (PREVIEW_ID_I == owner_reg);
  // Open only counts while the stream is free
  assign free_open = !prev_en_reg && PREVIEW_OPEN_I;

  // Run and preview next values
  always_comb begin
    proc_run_next = CAMERAS_OK_I;
    prev_en_next = prev_en_reg;
    owner_next = owner_reg;
    // Close wins over a same-cycle open from another page
    if (owner_close) begin
      prev_en_next = 1'b0;
    end else if (free_open) begin
      // first page claims the stream, later ones get nothing
      prev_en_next = 1'b1;
      owner_next = PREVIEW_ID_I;
    end
    // other hosts halted while preview runs
    host_en_next = !prev_en_next;
  end

  // Run and preview registers
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      proc_run_reg <= 1'b0;
      prev_en_reg <= 1'b0;
      owner_reg <= 4'h0;
      host_en_reg <= 1'b1;
    end else begin
      proc_run_reg <= proc_run_next;
      prev_en_reg <= prev_en_next;
      owner_reg <= owner_next;
      host_en_reg <= host_en_next;
    end
  end

  // =====================================================
  // Outputs, all straight from registers
  assign TAG_VALID_O = tag_valid_reg;
  assign TAG_O = tag_reg;
  assign PROC_RUN_O = proc_run_reg;
  assign HOST_XFER_EN_O = host_en_reg;
  assign PREVIEW_EN_O = prev_en_reg;
  assign PREVIEW_OWNER_O = owner_reg;

endmodule : dotsm_top

// >>> testbench/dotsm_chk.sv
// Port checker for the disparity output stage
`timescale 1ns/1ps
module dotsm_chk
  import dotsm_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic SRST_I,
  input wire logic CAMERAS_OK_I,
  input wire logic PAIR_DONE_I,
  input wire logic PREVIEW_OPEN_I,
  input wire logic [3:0] PREVIEW_ID_I,
  input wire logic PIX_VALID_I,
  input wire dotsm_pix_type PIX_I,
  input wire logic PIX_VALID_O,
  input wire logic [11:0] DISP_O,
  input wire logic [7:0] RAW_O,
  input wire logic TAG_VALID_O,
  input wire logic PROC_RUN_O,
  input wire logic HOST_XFER_EN_O,
  input wire logic PREVIEW_EN_O,
  input wire logic [3:0] PREVIEW_OWNER_O
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (SRST_I);
  // =====
  // Preview grant: free slot, then preview enabled
  sequence s_grant;
    PREVIEW_OPEN_I && !PREVIEW_EN_O ##1 PREVIEW_EN_O;
  endsequence
  chk_invalid_code: assert property (PIX_VALID_O && $past(PIX_I.invalid) |-> DISP_O == 12'hfff)
    else $error("invalid pixel code wrong");
  chk_disp_pass: assert property (PIX_VALID_O && !$past(PIX_I.invalid) |-> DISP_O == $past(PIX_I.disp))
    else $error("disparity code altered");
  chk_pix_cause: assert property (PIX_VALID_O |-> $past(PIX_VALID_I))
    else $error("pixel out without pixel in");
  chk_raw_int: assert property (PIX_VALID_O |-> RAW_O == DISP_O[11:4])
    else $error("raw value not integer part");
  chk_tag_cause: assert property (TAG_VALID_O |-> $past(PAIR_DONE_I))
    else $error("tag without finished pair");
  chk_preview_excl: assert property (PREVIEW_EN_O |-> !HOST_XFER_EN_O)
    else $error("host transfer during preview");
  chk_grant_owner: assert property (s_grant |-> PREVIEW_OWNER_O == $past(PREVIEW_ID_I))
    else $error("wrong preview owner");
  chk_owner_hold: assert property (PREVIEW_EN_O && $past(PREVIEW_EN_O) |-> $stable(PREVIEW_OWNER_O))
    else $error("preview owner changed");
  chk_host_resume: assert property ($fell(PREVIEW_EN_O) |-> ##[0:1] HOST_XFER_EN_O)
    else $error("host transfer not resumed");
  chk_auto_start: assert property (CAMERAS_OK_I |-> ##[1:3] PROC_RUN_O)
    else $error("processing did not start");
endmodule : dotsm_chk

bind dotsm_top dotsm_chk dotsm_chk_inst (.CORE_CLK_I(CORE_CLK_I), .SRST_I(SRST_I),
  .CAMERAS_OK_I(CAMERAS_OK_I), .PAIR_DONE_I(PAIR_DONE_I), .PREVIEW_OPEN_I(PREVIEW_OPEN_I),
  .PREVIEW_ID_I(PREVIEW_ID_I), .PIX_VALID_I(PIX_VALID_I), .PIX_I(PIX_I), .PIX_VALID_O(PIX_VALID_O),
  .DISP_O(DISP_O), .RAW_O(RAW_O), .TAG_VALID_O(TAG_VALID_O), .PROC_RUN_O(PROC_RUN_O),
  .HOST_XFER_EN_O(HOST_XFER_EN_O), .PREVIEW_EN_O(PREVIEW_EN_O), .PREVIEW_OWNER_O(PREVIEW_OWNER_O));

// >>> testbench/dotsm_host_model.sv
// Host receiver model for tagged result pairs
`timescale 1ns/1ps
module dotsm_host_model
  import dotsm_pkg::*;
(
  input wire logic clk_i,
  input wire logic xfer_en_i,
  input wire logic tag_valid_i,
  input wire logic pix_valid_i,
  input wire logic [11:0] disp_i,
  output int count_o,
  output logic [7:0] mag_o
);
  // =====
  // Receive only while the host path is open
  initial count_o = 0;
  initial mag_o = 8'h00;
  always @(posedge clk_i) begin
    if (xfer_en_i && tag_valid_i) begin
      count_o <= count_o + 1;
    end
    if (xfer_en_i && pix_valid_i && disp_i != DISP_INVALID) begin
      mag_o <= 8'(disp_i / 16);
    end
  end
endmodule : dotsm_host_model

// >>> testbench/tb_dotsm_top.sv
// Self-checking bench for the disparity output stage
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin num_errors++; $display("ERROR %0t %h %h", $time, a, e); end end
module tb_dotsm_top
  import dotsm_pkg::*;
;
  logic clk, srst, spin, sload, trig, frx, nsrc, pdone, camok, popen, pclose, pvi;
  logic pvo, tvo, prun, hxe, pen;
  dotsm_sync_type smode;
  dotsm_tsrc_type tsrc;
  logic [63:0] stime;
  dotsm_tag_type ntag, tag;
  dotsm_pix_type pix;
  logic [3:0] pid, pown;
  logic [11:0] disp;
  logic [7:0] raw, hmag;
  int num_errors, checked, cycles, hcount;
  dotsm_top dotsm_top_inst (.CORE_CLK_I(clk), .SRST_I(srst), .SYNC_MODE_I(smode), .TS_SRC_I(tsrc),
    .SYNC_PIN_I(spin), .SERVER_LOAD_I(sload), .SERVER_TIME_I(stime), .TRIGGER_I(trig), .FRAME_RX_I(frx),
    .NET_SOURCE_I(nsrc), .NET_TAG_I(ntag), .PAIR_DONE_I(pdone), .CAMERAS_OK_I(camok),
    .PREVIEW_OPEN_I(popen), .PREVIEW_ID_I(pid), .PREVIEW_CLOSE_I(pclose), .PIX_VALID_I(pvi), .PIX_I(pix),
    .PIX_VALID_O(pvo), .DISP_O(disp), .RAW_O(raw), .TAG_VALID_O(tvo), .TAG_O(tag), .PROC_RUN_O(prun),
    .HOST_XFER_EN_O(hxe), .PREVIEW_EN_O(pen), .PREVIEW_OWNER_O(pown));
  dotsm_host_model dotsm_host_model_inst (.clk_i(clk), .xfer_en_i(hxe), .tag_valid_i(tvo),
    .pix_valid_i(pvo), .disp_i(disp), .count_o(hcount), .mag_o(hmag));
  // =====
  // Clock and hang guard
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      print_verdict();
    end
  end
  task print_verdict();
    $display("checked=%0d num_errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  // =====
  // One pair: frame, valid and invalid pixel, done, tag
  task send_pair(input dotsm_tag_type exp);
    frx = 1; cyc(1); frx = 0; cyc(2);
    pix = {12'h2a7, 1'b0}; pvi = 1; cyc(1);
    `CHK(pvo, 1'b1)
    `CHK(disp, 12'h2a7)
    `CHK(raw, 8'h2a)
    pix = {12'h013, 1'b1}; cyc(1); pvi = 0;
    `CHK(disp, 12'hfff)
    `CHK(raw, 8'hff)
    pdone = 1; cyc(1); pdone = 0;
    `CHK(tvo, 1'b1)
    `CHK(tag, exp)
    cyc(2);
  endtask : send_pair
  task t_reset();
    `CHK(hxe, 1'b1)
    camok = 1; cyc(3);
    `CHK(prun, 1'b1)
    cyc(247); trig = 1; cyc(1); trig = 0;
    send_pair({64'd2, 32'd0});
  endtask : t_reset
  task t_pin();
    smode = DOTSM_SYNC_PIN; spin = 1; cyc(350);
    trig = 1; cyc(1); trig = 0; spin = 0;
    send_pair({64'd3, 32'd1});
    `CHK(tag.seq, 32'd1)
  endtask : t_pin
  // Sync edge while waiting for the frame
  task t_neg();
    spin = 1; cyc(50); trig = 1; cyc(1); trig = 0; spin = 0;
    cyc(299); spin = 1; cyc(10); spin = 0;
    send_pair({64'hffff_ffff_ffff_fffd, 32'd2});
  endtask : t_neg
  task t_server();
    smode = DOTSM_SYNC_SERVER; tsrc = DOTSM_SRC_RECEIVE; stime = 64'h0005_0000_0000_0000;
    sload = 1; cyc(1); sload = 0; cyc(150);
    send_pair({64'h0005_0000_0000_0001, 32'd3});
    `CHK(tag.stamp, 64'h0005_0000_0000_0001)
  endtask : t_server
  task t_net();
    nsrc = 1; ntag = {64'h0123_4567_89ab_cdef, 32'h0000_00a5};
    send_pair(ntag);
    nsrc = 0;
    `CHK(hcount, 5)
    `CHK(hmag, 8'h2a)
  endtask : t_net
  task t_preview();
    pid = 4'h3; popen = 1; cyc(1); pid = 4'h5;
    `CHK(hxe, 1'b0)
    cyc(1); popen = 0; pclose = 1; cyc(1);
    `CHK(pown, 4'h3)
    `CHK(pen, 1'b1)
    pid = 4'h3; cyc(1); pclose = 0; cyc(1);
    `CHK(hxe, 1'b1)
  endtask : t_preview
  initial begin
    num_errors = 0; checked = 0;
    srst = 1; smode = DOTSM_SYNC_NONE; tsrc = DOTSM_SRC_TRIGGER;
    {spin, sload, trig, frx, nsrc, pdone, camok, popen, pclose, pvi} = '0;
    stime = '0; ntag = '0; pid = '0; pix = '0;
    cyc(6); srst = 0;
    t_reset(); t_pin(); t_neg(); t_server(); t_net(); t_preview();
    print_verdict();
  end
endmodule : tb_dotsm_top
